// ===== hw/ocf_osc_ctl.sv
// Oscillator control with write lock, source select and clock failure recovery
// Function
// - Control register unlocks only after writes of E7H then 18H.
// - Next write once unlocked updates register and relocks immediately.
// - Any other write sequence leaves the control register unchanged.
// - Unlock keys must be ordered but need not be consecutive bus cycles.
// - Accesses to other registers do not disturb unlock progress.
// - Internal precision oscillator is enabled after reset.
// - Changing source never disables the internal precision oscillator itself.
// - Primary oscillator failure raises a non-maskable interrupt-like event.
// - Primary failure forces the watchdog oscillator onto the system clock.
// - Recovery switch happens only while the watchdog oscillator is enabled.
// - No recovery switch when watchdog oscillator is the selected source.
// - Recovery needs only the watchdog oscillator, not its reset function.
// - Failure asserts when clock activity drops below about 1 kHz.
// - After switchover the CPU keeps running and takes the failure vector.
`timescale 1ns/1ns
`default_nettype none
module ocf_osc_ctl
	import ocf_pkg::*;
#(
	parameter int FAIL_LIMIT = ocf_pkg::FAIL_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ocf_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic ipo_tick,
	input wire logic xtal_tick,
	input wire logic ext_tick,
	input wire logic wdt_tick,
	input wire logic nmi_ack,
	output logic ipo_enable,
	output logic xtal_enable,
	output logic wdt_osc_enable,
	output logic [2:0] sys_clk_select,
	output logic clock_fail_nmi,
	output logic irq
);
	import ocf_pkg::*;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic addr_is(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
		addr_is = (a[ADDR_W-1:2] == off[ADDR_W-1:2]);
	endfunction

	function automatic logic [MON_W-1:0] limit_of(input int lim);
		limit_of = (lim < 1) ? MON_W'(1) : MON_W'(lim);
	endfunction

	// ----------------------------------------
	// Storage
	// ----------------------------------------
	logic [7:0] osc_control_reg;
	ocf_lock_t lock_state;
	ocf_lock_t next_lock_state;
	logic [ST_W-1:0] status;
	logic [ST_W-1:0] mask;
	logic [ST_W-1:0] rd_status_snap;
	logic recovery;
	logic nmi_pending;
	logic pri_fail_d;
	logic wdt_fail_d;

	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	wire setup_ph = psel && !penable;
	wire access_ph = psel && penable;
	wire hit_ctl = addr_is(paddr, OFF_OSC_CTL);
	wire hit_status = addr_is(paddr, OFF_STATUS);
	wire hit_mask = addr_is(paddr, OFF_MASK);
	wire hit_state = addr_is(paddr, OFF_STATE);
	wire addr_ok = hit_ctl || hit_status || hit_mask || hit_state;
	wire wr_ok = access_ph && pwrite && addr_ok;
	wire rd_ok = access_ph && !pwrite && addr_ok;
	wire ctl_wr = wr_ok && hit_ctl;
	wire mask_wr = wr_ok && hit_mask;
	wire status_rd = rd_ok && hit_status;
	wire [7:0] wr_byte = pwdata[7:0];

	assign pready = 1'b1;
	assign pslverr = access_ph && !addr_ok;

	// ----------------------------------------
	// Control register fields
	// ----------------------------------------
	wire [SEL_W-1:0] sel_field = osc_control_reg[SEL_LSB +: SEL_W];
	wire pri_fail_en = osc_control_reg[BIT_PRI_FAIL_EN];
	wire wdt_fail_en = osc_control_reg[BIT_WDT_FAIL_EN];
	wire wdt_osc_on = osc_control_reg[BIT_WDT_OSC_EN];
	wire sel_is_wdt = (sel_field == SRC_WDT);

	// ----------------------------------------
	// Unlock sequencer
	// ----------------------------------------
	// Only writes to the control address move the sequencer
	always_comb begin
		next_lock_state = lock_state;
		if (ctl_wr) begin
			unique case (lock_state)
				ocf_locked_st: begin
					if (wr_byte == UNLOCK_KEY_FIRST) begin
						next_lock_state = ocf_key1_st;
					end
				end
				ocf_key1_st: begin
					if (wr_byte == UNLOCK_KEY_SECOND) begin
						next_lock_state = ocf_open_st;
					end else if (wr_byte == UNLOCK_KEY_FIRST) begin
						next_lock_state = ocf_key1_st;
					end else begin
						next_lock_state = ocf_locked_st;
					end
				end
				ocf_open_st: begin
					next_lock_state = ocf_locked_st;
				end
				default: begin
					next_lock_state = ocf_locked_st;
				end
			endcase
		end
	end

	wire ctl_commit = ctl_wr && (lock_state == ocf_open_st);

	// ----------------------------------------
	// Lock state register
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_state <= ocf_locked_st;
		end else begin
			lock_state <= next_lock_state;
		end
	end

	// ----------------------------------------
	// Protected control register
	// ----------------------------------------
	// Register changes only on the write after a full unlock
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_control_reg <= OSC_CTL_RESET;
		end else if (ctl_commit) begin
			osc_control_reg <= wr_byte;
		end
	end

	// ----------------------------------------
	// Failure monitors
	// ----------------------------------------
	logic sel_tick;
	logic pri_fail;
	logic wdt_fail;

	// ----------------------------------------
	// Tick of the selected source
	// ----------------------------------------
	always_comb begin
		unique case (sel_field)
			SRC_XTAL: sel_tick = xtal_tick;
			SRC_EXT: sel_tick = ext_tick;
			SRC_WDT: sel_tick = wdt_tick;
			default: sel_tick = ipo_tick;
		endcase
	end

	// Watchdog source as primary has no recovery path
	wire pri_mon_en = pri_fail_en && !sel_is_wdt && !recovery;
	wire wdt_mon_en = wdt_fail_en && wdt_osc_on;

	ocf_rate_mon u_pri_mon (
		.pclk(pclk),
		.presetn(presetn),
		.enable(pri_mon_en),
		.tick(sel_tick),
		.limit(limit_of(FAIL_LIMIT)),
		.fail(pri_fail)
	);

	ocf_rate_mon u_wdt_mon (
		.pclk(pclk),
		.presetn(presetn),
		.enable(wdt_mon_en),
		.tick(wdt_tick),
		.limit(limit_of(FAIL_LIMIT)),
		.fail(wdt_fail)
	);

	// ----------------------------------------
	// Failure edge detect
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pri_fail_d <= 1'b0;
			wdt_fail_d <= 1'b0;
		end else begin
			pri_fail_d <= pri_fail;
			wdt_fail_d <= wdt_fail;
		end
	end

	// ----------------------------------------
	// Failure events
	// ----------------------------------------
	wire pri_fail_evt = pri_fail && !pri_fail_d;
	wire wdt_fail_evt = wdt_fail && !wdt_fail_d;
	// Recovery needs only the watchdog oscillator running
	wire recover_evt = pri_fail_evt && wdt_osc_on && !sel_is_wdt;

	// ----------------------------------------
	// Recovery switchover
	// ----------------------------------------
	// Held until software commits a new control value
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			recovery <= 1'b0;
		end else if (recover_evt) begin
			recovery <= 1'b1;
		end else if (ctl_commit) begin
			recovery <= 1'b0;
		end
	end

	wire [2:0] next_clk_select = recovery ? SRC_WDT : sel_field;

	// ----------------------------------------
	// Effective clock select
	// ----------------------------------------

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sys_clk_select <= SRC_IPO;
		end else begin
			sys_clk_select <= next_clk_select;
		end
	end

	// ----------------------------------------
	// Oscillator enables
	// ----------------------------------------
	assign ipo_enable = osc_control_reg[BIT_IPO_EN];
	assign xtal_enable = osc_control_reg[BIT_XTAL_EN];
	assign wdt_osc_enable = wdt_osc_on;

	// ----------------------------------------
	// Non-maskable failure event
	// ----------------------------------------
	// Not gated by the mask; a new event beats the acknowledge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nmi_pending <= 1'b0;
		end else if (pri_fail_evt || wdt_fail_evt) begin
			nmi_pending <= 1'b1;
		end else if (nmi_ack) begin
			nmi_pending <= 1'b0;
		end
	end

	assign clock_fail_nmi = nmi_pending;

	// ----------------------------------------
	// Status, mask and interrupt
	// ----------------------------------------
	wire [ST_W-1:0] st_set = {recover_evt, wdt_fail_evt, pri_fail_evt};
	wire [ST_W-1:0] st_clr = status_rd ? rd_status_snap : '0;
	wire [ST_W-1:0] next_status = (status & ~st_clr) | st_set;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status <= ST_RESET;
		end else begin
			status <= next_status;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask <= MASK_RESET;
		end else if (mask_wr) begin
			mask <= pwdata[ST_W-1:0];
		end
	end

	assign irq = |(status & mask);

	// ----------------------------------------
	// Read data, captured in the setup cycle
	// ----------------------------------------
	logic [31:0] rd_mux;

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (hit_ctl) begin
			rd_mux = {24'h00_0000, osc_control_reg};
		end else if (hit_status) begin
			rd_mux = {29'h0000_0000, status};
		end else if (hit_mask) begin
			rd_mux = {29'h0000_0000, mask};
		end else if (hit_state) begin
			rd_mux = {25'h000_0000, nmi_pending, recovery, next_clk_select, lock_state};
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0000_0000;
		end else if (setup_ph && !pwrite) begin
			prdata <= rd_mux;
		end
	end

	// ----------------------------------------
	// Status clear snapshot
	// ----------------------------------------
	// Only bits the reader has seen get cleared
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_status_snap <= ST_RESET;
		end else if (setup_ph && !pwrite) begin
			rd_status_snap <= hit_status ? status : ST_RESET;
		end
	end

endmodule // ocf_osc_ctl
`default_nettype wire

// ===== hw/ocf_pkg.sv
// Constants for the oscillator control, lock and clock failure recovery block
package ocf_pkg;

	// ----------------------------------------
	// Bus geometry and register offsets
	// ----------------------------------------
	localparam int ADDR_W = 12;
	localparam logic [11:0] OFF_OSC_CTL = 12'h000;
	localparam logic [11:0] OFF_STATUS = 12'h004;
	localparam logic [11:0] OFF_MASK = 12'h008;
	localparam logic [11:0] OFF_STATE = 12'h00c;

	// ----------------------------------------
	// Oscillator control register fields
	// ----------------------------------------
	localparam int BIT_IPO_EN = 7;
	localparam int BIT_XTAL_EN = 6;
	localparam int BIT_WDT_OSC_EN = 5;
	localparam int BIT_PRI_FAIL_EN = 4;
	localparam int BIT_WDT_FAIL_EN = 3;
	localparam int SEL_LSB = 0;
	localparam int SEL_W = 3;
	localparam logic [7:0] OSC_CTL_RESET = 8'ha0;

	// Unlock key values
	localparam logic [7:0] UNLOCK_KEY_FIRST = 8'he7;
	localparam logic [7:0] UNLOCK_KEY_SECOND = 8'h18;

	// Clock source encodings
	localparam logic [2:0] SRC_IPO = 3'h0;
	localparam logic [2:0] SRC_XTAL = 3'h1;
	localparam logic [2:0] SRC_EXT = 3'h2;
	localparam logic [2:0] SRC_WDT = 3'h3;

	// ----------------------------------------
	// Status / mask bits
	// ----------------------------------------
	localparam int ST_W = 3;
	localparam int ST_PRI_FAIL = 0;
	localparam int ST_WDT_FAIL = 1;
	localparam int ST_RECOVER = 2;
	localparam logic [2:0] ST_RESET = 3'h0;
	localparam logic [2:0] MASK_RESET = 3'h0;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int FAIL_PERIOD_NS = 1000000;
	localparam int FAIL_CYCLES = FAIL_PERIOD_NS / CLK_PERIOD_NS;
	localparam int MON_W = 16;

	typedef enum logic [1:0] {
		ocf_locked_st = 2'b00,
		ocf_key1_st = 2'b01,
		ocf_open_st = 2'b10
	} ocf_lock_t;

endpackage

// ===== hw/ocf_rate_mon.sv
// Oscillator activity monitor: flags a source whose ticks stop arriving
`timescale 1ns/1ns
`default_nettype none
module ocf_rate_mon
	import ocf_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic enable,
	input wire logic tick,
	input wire logic [ocf_pkg::MON_W-1:0] limit,
	output logic fail
);

	logic [MON_W-1:0] count;
	wire at_limit = (count >= limit);

	// ----------------------------------------
	// Gap counter, restarted by every tick
	// ----------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			count <= '0;
		end else if (!enable || tick) begin
			count <= '0;
		end else if (!at_limit) begin
			count <= count + 1'b1;
		end
	end

	// Level stays while the gap lasts
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fail <= 1'b0;
		end else begin
			fail <= enable && !tick && at_limit;
		end
	end

endmodule // ocf_rate_mon
`default_nettype wire

// ===== verification/ocf_osc_ctl_props.sv
// Assertion checker for the oscillator control block
`timescale 1ns/1ns
`default_nettype none
module ocf_osc_ctl_chk
	import ocf_pkg::*;
#(
	parameter int FAIL_LIMIT = 20
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ocf_pkg::ADDR_W-1:0] paddr,
	input wire logic pslverr,
	input wire logic xtal_tick,
	input wire logic nmi_ack,
	input wire logic ipo_enable,
	input wire logic xtal_enable,
	input wire logic wdt_osc_enable,
	input wire logic [2:0] sys_clk_select,
	input wire logic clock_fail_nmi
);
	import ocf_pkg::*;
	wire logic wr = psel && penable && pwrite;
	wire logic wr_ctl = wr && paddr[11:2] == 10'h000;
	wire logic [2:0] ens = {ipo_enable, xtal_enable, wdt_osc_enable};
	logic [15:0] gap;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Cycles since the last crystal tick
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			gap <= 16'h0000;
		else if (xtal_tick)
			gap <= 16'h0000;
		else if (gap != 16'hffff)
			gap <= gap + 16'h0001;
	end
	property p_reset_ipo;
		!$past(presetn) |-> ipo_enable;
	endproperty
	a_reset_ipo: assert property (p_reset_ipo) else $error("ipo off after reset");
	property p_ctl_lock;
		!$stable(ens) |-> $past(wr_ctl);
	endproperty
	a_ctl_lock: assert property (p_ctl_lock) else $error("enables moved without write");
	property p_other_wr;
		wr && paddr[11:2] != 10'h000 |=> $stable(ens);
	endproperty
	a_other_wr: assert property (p_other_wr) else $error("other write hit control");
	property p_nmi_hold;
		$fell(clock_fail_nmi) |-> $past(nmi_ack);
	endproperty
	a_nmi_hold: assert property (p_nmi_hold) else $error("nmi dropped without ack");
	property p_recover;
		$rose(clock_fail_nmi) && sys_clk_select == SRC_XTAL && wdt_osc_enable
			&& gap > FAIL_LIMIT |=> sys_clk_select == SRC_WDT;
	endproperty
	a_recover: assert property (p_recover) else $error("no switch to wdt osc");
	property p_need_wdt;
		$rose(sys_clk_select == SRC_WDT) |-> $past(wr_ctl) || $past(wr_ctl, 2)
			|| ($past(clock_fail_nmi) && $past(wdt_osc_enable));
	endproperty
	a_need_wdt: assert property (p_need_wdt) else $error("switch with wdt osc off");
	property p_wdt_sel;
		sys_clk_select == SRC_WDT && !wr_ctl && !$past(wr_ctl) |=> $stable(sys_clk_select);
	endproperty
	a_wdt_sel: assert property (p_wdt_sel) else $error("wdt source left alone");
	property p_ipo_kept;
		$changed(sys_clk_select) && !$past(wr_ctl) && !$past(wr_ctl, 2) |-> $stable(ipo_enable);
	endproperty
	a_ipo_kept: assert property (p_ipo_kept) else $error("ipo dropped on switch");
	c_fail: cover property ($rose(clock_fail_nmi));
	c_recover: cover property ($rose(sys_clk_select == SRC_WDT));
	c_err: cover property (pslverr);
endmodule // ocf_osc_ctl_chk
bind ocf_osc_ctl ocf_osc_ctl_chk #(.FAIL_LIMIT(FAIL_LIMIT)) i_chk (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .pslverr, .xtal_tick, .nmi_ack, .ipo_enable, .xtal_enable,
	.wdt_osc_enable, .sys_clk_select, .clock_fail_nmi);
`default_nettype wire

// ===== verification/tb_top.sv
// Self-checking bench for the oscillator control block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import ocf_pkg::*;
	typedef struct packed {logic w; logic [11:0] a; logic [7:0] d; logic [7:0] e;} ocf_row_t;
	localparam int LIMIT = 20;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, nmi_ack = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000;
	logic [31:0] prdata, rd;
	logic pready, pslverr, serr, ipo_enable, xtal_enable, wdt_osc_enable, clock_fail_nmi, irq;
	logic [2:0] sys_clk_select;
	logic ipo_tick = 1'b0, xtal_tick = 1'b0, ext_tick = 1'b0, wdt_tick = 1'b0;
	logic [3:0] run = 4'hf;
	logic [1:0] div = 2'h0;
	int fails = 0, tests_run = 0, cyc = 0;
	ocf_row_t rows[18] = '{'{0,12'h000,8'h00,8'ha0}, '{1,12'h000,8'h00,8'h00},
		'{0,12'h000,8'h00,8'ha0}, '{1,12'h000,8'he7,8'h00}, '{0,12'h008,8'h00,8'h00},
		'{1,12'h008,8'h00,8'h00}, '{1,12'h000,8'h18,8'h00}, '{0,12'h000,8'h00,8'ha0},
		'{1,12'h000,8'he1,8'h00}, '{0,12'h000,8'h00,8'he1}, '{1,12'h000,8'h00,8'h00},
		'{0,12'h000,8'h00,8'he1}, '{1,12'h000,8'he7,8'h00}, '{1,12'h000,8'h55,8'h00},
		'{1,12'h000,8'h18,8'h00}, '{1,12'h000,8'h00,8'h00}, '{0,12'h000,8'h00,8'he1},
		'{0,12'h00c,8'h00,8'h04}};
	ocf_osc_ctl #(.FAIL_LIMIT(LIMIT)) i_dut (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .ipo_tick, .xtal_tick, .ext_tick,
		.wdt_tick, .nmi_ack, .ipo_enable, .xtal_enable, .wdt_osc_enable, .sys_clk_select,
		.clock_fail_nmi, .irq);
	always #50 pclk = ~pclk;
	// One tick every four cycles on each running source
	always @(posedge pclk) begin
		div <= div + 2'h1;
		{wdt_tick, ext_tick, xtal_tick, ipo_tick} <= run & {4{div == 2'h0}};
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			fails++;
			results();
		end
	end
	task automatic results;
		$display("comparisons %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			fails++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask
	task automatic commit(input logic [7:0] v);
		xfer(1'b1, OFF_OSC_CTL, 32'h0000_00e7);
		xfer(1'b1, OFF_OSC_CTL, 32'h0000_0018);
		xfer(1'b1, OFF_OSC_CTL, {24'h00_0000, v});
	endtask
	task automatic wait_nmi(input int lim);
		int n;
		n = 0;
		while (clock_fail_nmi !== 1'b1 && n < lim) begin
			@(posedge pclk);
			#1;
			n++;
		end
	endtask
	task automatic ack_nmi;
		@(posedge pclk);
		nmi_ack <= 1'b1;
		@(posedge pclk);
		nmi_ack <= 1'b0;
		#1;
	endtask
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		foreach (rows[i]) begin
			xfer(rows[i].w, rows[i].a, {24'h00_0000, rows[i].d});
			if (!rows[i].w) chk(rd, {24'h00_0000, rows[i].e});
		end
		xfer(1'b0, 12'h010, 32'h0000_0000);
		chk(serr, 1'b1);
		$display("register table test done");
		// Select crystal with primary detection and watchdog oscillator on in one commit
		commit(8'hf1);
		// Crystal stops while selected
		@(posedge pclk);
		run[1] <= 1'b0;
		repeat (LIMIT - 4) @(posedge pclk);
		#1;
		chk(clock_fail_nmi, 1'b0);
		wait_nmi(12);
		chk(clock_fail_nmi, 1'b1);
		chk(irq, 1'b0);
		repeat (2) @(posedge pclk);
		#1;
		chk(sys_clk_select, SRC_WDT);
		xfer(1'b1, OFF_MASK, 32'h0000_0001);
		chk(irq, 1'b1);
		xfer(1'b0, OFF_STATUS, 32'h0000_0000);
		chk(rd, 32'h0000_0005);
		chk(irq, 1'b0);
		ack_nmi();
		chk(clock_fail_nmi, 1'b0);
		xfer(1'b0, OFF_STATE, 32'h0000_0000);
		chk(rd, 32'h0000_002c);
		$display("failure recovery test done");
		// Watchdog oscillator off: no switch
		commit(8'h81);
		commit(8'h91);
		wait_nmi(60);
		repeat (3) @(posedge pclk);
		#1;
		chk(clock_fail_nmi, 1'b1);
		chk(sys_clk_select, SRC_XTAL);
		chk(ipo_enable, 1'b1);
		ack_nmi();
		// Watchdog oscillator as the source
		commit(8'ha3);
		commit(8'hb3);
		repeat (60) @(posedge pclk);
		#1;
		chk(clock_fail_nmi, 1'b0);
		chk(sys_clk_select, SRC_WDT);
		$display("no recovery test done");
		// Reset in mid-run drops a finished unlock
		xfer(1'b1, OFF_OSC_CTL, 32'h0000_00e7);
		xfer(1'b1, OFF_OSC_CTL, 32'h0000_0018);
		@(posedge pclk);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		xfer(1'b1, OFF_OSC_CTL, 32'h0000_0011);
		xfer(1'b0, OFF_OSC_CTL, 32'h0000_0000);
		chk(rd, 32'h0000_00a0);
		chk(sys_clk_select, SRC_IPO);
		chk(clock_fail_nmi, 1'b0);
		$display("reset test done");
		results();
	end
endmodule // tb_top
`default_nettype wire
